// ===== brs_burst_seq.sv
// Burst word sequencer with row-crossing stall indicator
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module brs_burst_seq (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  // Host bus pins, asynchronous to core_clk
  input  wire brs_pkg::brs_pins_s                  pins_in,
  // Stall indicator pin
  output logic                                     wait_out,
  output logic                                     wait_oe,
  // Word sequence toward the array
  output logic [brs_pkg::BRS_ADDR_W-1:0]           word_addr,
  output logic                                     word_valid,
  // Register port
  input  wire brs_pkg::brs_reg_req_s               reg_req,
  output logic [15:0]                              reg_rdata
);
  import brs_pkg::*;

  brs_state_s            r;
  brs_state_s            n;
  brs_status_s           stat;
  logic                  cs;
  logic                  adv;
  logic                  cont;
  logic                  wrap_on;
  logic                  misaligned;
  logic                  emit;
  logic                  emit_last;
  logic                  emit_stall;
  logic                  last_word;
  logic                  cur_stall;
  logic [2:0]            mask;
  logic [2:0]            sub;
  logic [2:0]            lat_eff;
  logic [2:0]            stall_len;
  logic [2:0]            low;
  logic [2:0]            exp_cnt;
  logic [3:0]            emit_seq;
  logic [BRS_ADDR_W-1:0] mask_w;
  logic [BRS_ADDR_W-1:0] addr_next;
  logic [BRS_ADDR_W-1:0] emit_addr;

  // Row nibble and group arithmetic need at least five address bits
  if (BRS_ADDR_W < 5) begin : g_bad_width
    $error("brs_burst_seq: address width below 5");
  end

  // Pins only reach logic through the second sync stage
  assign cs  = !r.pin_s2.chip_sel_n;
  assign adv = !r.pin_s2.adv_n;

  // Burst length decode; unknown codes behave as continuous
  always_comb begin
    cont = 1'b0;
    mask = BRS_MASK_4;
    case (r.cfg.burst_length_field)
      BRS_BL_4: mask = BRS_MASK_4;
      BRS_BL_8: mask = BRS_MASK_8;
      BRS_BL_CONT: begin
        cont = 1'b1;
        mask = '0;
      end
      default: begin
        cont = 1'b1;
        mask = '0;
      end
    endcase
  end

  // Wrap applies only to fixed lengths, and only with the bit clear
  assign wrap_on = !r.cfg.wrap_select && !cont;
  assign mask_w  = {{(BRS_ADDR_W-3){1'b0}}, mask};

  // Next word address
  assign emit_seq = (r.st == BRS_LAT) ? 4'h0 : 4'(r.seq + 4'h1);
  assign low      = r.cfg.burst_order_select ? (r.start[2:0] ^ emit_seq[2:0])
                                             : 3'(r.start[2:0] + emit_seq[2:0]);
  // Without wrap the order bit is ignored: interleave has no meaning there
  assign addr_next = wrap_on ? ((r.start & ~mask_w) | ({{(BRS_ADDR_W-3){1'b0}}, low} & mask_w))
                             : BRS_ADDR_W'(r.word_addr + 1'b1);
  assign emit_addr = (r.st == BRS_LAT) ? r.start : addr_next;

  // Stall length from start offset and latency
  assign misaligned = r.start[1:0] != 2'h0;
  always_comb begin
    case (r.start[1:0])
      2'h1:    sub = BRS_SUB_01;
      2'h2:    sub = BRS_SUB_10;
      2'h3:    sub = BRS_SUB_11;
      default: sub = 3'h0;
    endcase
  end
  assign lat_eff   = (r.cfg.first_access_latency == 3'h0) ? 3'h1 : r.cfg.first_access_latency;
  // Short latencies saturate at no stall instead of wrapping negative
  assign stall_len = (misaligned && r.cfg.first_access_latency > sub) ?
                     3'(r.cfg.first_access_latency - sub) : 3'h0;

  // Row end detection for the word just sent and the word about to go
  assign last_word  = !cont && (r.seq == {1'b0, mask});
  assign emit_last  = !cont && (emit_seq == {1'b0, mask});
  assign cur_stall  = (r.word_addr[3:0] == BRS_ROW_LAST) && (stall_len != 3'h0)
                      && !wrap_on && !r.stall_done && !last_word;
  assign emit_stall = (emit_addr[3:0] == BRS_ROW_LAST) && (stall_len != 3'h0)
                      && !wrap_on && !r.stall_done && !emit_last;

  // Status view
  assign stat = '{rsvd: '0, wait_act: r.wait_act, stall_done: r.stall_done,
                  word_vld: r.word_vld, st: r.st};

  // Next-state logic
  always_comb begin
    n          = r;
    emit       = 1'b0;
    n.pin_s1   = pins_in;
    n.pin_s2   = r.pin_s1;
    n.word_vld = 1'b0;
    n.rdata    = '0;
    // Register port; read data valid only in the following cycle
    if (reg_req.wr && reg_req.addr == BRS_REG_CONFIG) begin
      n.cfg = brs_cfg_s'(reg_req.wdata);
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        BRS_REG_CONFIG: n.rdata = r.cfg;
        BRS_REG_STATUS: n.rdata = stat;
        default:        n.rdata = '0;
      endcase
    end
    // Burst sequencing; dropping chip select abandons the burst
    if (!cs) begin
      n.st = BRS_IDLE;
    end else if (adv) begin
      n.st         = BRS_LAT;
      n.start      = r.pin_s2.addr;
      n.word_addr  = r.pin_s2.addr;
      n.lat_cnt    = lat_eff;
      n.seq        = 4'h0;
      n.stall_done = 1'b0;
    end else begin
      case (r.st)
        BRS_LAT: begin
          if (r.lat_cnt <= 3'h1) begin
            n.st = BRS_DATA;
            emit = 1'b1;
          end else begin
            n.lat_cnt = r.lat_cnt - 3'h1;
          end
        end
        BRS_DATA: begin
          if (last_word) begin
            n.st = BRS_IDLE;
          end else if (cur_stall) begin
            // This cycle is the first gap cycle of the row switch
            n.st         = BRS_STALL;
            n.stall_cnt  = stall_len - 3'h1;
            n.stall_done = 1'b1;
          end else begin
            emit = 1'b1;
          end
        end
        BRS_STALL: begin
          // No word is offered while stalled, so the host cannot take one
          if (r.stall_cnt == 3'h0) begin
            n.st = BRS_DATA;
            emit = 1'b1;
          end else begin
            n.stall_cnt = r.stall_cnt - 3'h1;
          end
        end
        default: n.st = BRS_IDLE;
      endcase
    end
    if (emit) begin
      n.word_vld  = 1'b1;
      n.word_addr = emit_addr;
      n.seq       = emit_seq;
    end
    // Asserted whenever the bus holds no valid word, or early before a stall
    n.wait_act = !n.word_vld || (r.cfg.stall_timing_select && emit && emit_stall);
    n.wait_oe  = cs && !r.pin_s2.reg_info;
    n.wait_pin = r.cfg.stall_polarity ? n.wait_act : !n.wait_act;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r        <= '0;
      r.cfg    <= BRS_CFG_RESET;
      r.pin_s1 <= BRS_PINS_IDLE;
      r.pin_s2 <= BRS_PINS_IDLE;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops
  assign wait_out   = r.wait_pin;
  assign wait_oe    = r.wait_oe;
  assign word_addr  = r.word_addr;
  assign word_valid = r.word_vld;
  assign reg_rdata  = r.rdata;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  assign exp_cnt = 3'(r.cfg.first_access_latency - sub - 3'h1);

  a_oe_follows_cs: assert property (cs && !r.pin_s2.reg_info |=> wait_oe)
    else $error("stall pin not driven under chip select");
  a_reg_info_released: assert property (r.pin_s2.reg_info |=> !wait_oe)
    else $error("stall pin driven during register read");
  a_stall_misaligned: assert property (r.st == BRS_STALL |-> misaligned)
    else $error("stall on aligned start");
  a_stall_only_once: assert property (r.st == BRS_DATA && r.stall_done && cs && !adv |=> r.st != BRS_STALL)
    else $error("second stall in one burst");
  a_stall_length: assert property (r.st == BRS_DATA && cur_stall && cs && !adv |=> r.stall_cnt == $past(exp_cnt))
    else $error("stall count differs from latency minus offset");
  a_wrap_no_stall: assert property (wrap_on |-> r.st != BRS_STALL)
    else $error("stall with wrap on");
  a_linear_step: assert property (r.word_vld && $past(r.word_vld) && !wrap_on && $past(r.st) == BRS_DATA
                                  |-> r.word_addr == BRS_ADDR_W'($past(r.word_addr) + 1'b1))
    else $error("unwrapped burst not consecutive");
  a_wrap_in_group: assert property (r.word_vld && wrap_on |-> ((r.word_addr ^ r.start) & ~mask_w) == '0)
    else $error("wrapped word left its group");
  a_pin_polarity: assert property (wait_oe && !word_valid |-> wait_out == r.cfg.stall_polarity)
    else $error("stall level wrong for polarity");
  a_row_cross_at: assert property (r.st == BRS_DATA ##1 r.st == BRS_STALL |-> r.word_addr[3:0] == BRS_ROW_LAST)
    else $error("stall not at row end");

  c_stall_seen: cover property (r.st == BRS_DATA ##1 r.st == BRS_STALL);
  c_interleave_8: cover property (word_valid && wrap_on && r.cfg.burst_order_select && mask == BRS_MASK_8);
  c_cont_cross: cover property (cont && r.st == BRS_STALL ##[1:8] word_valid);
endmodule : brs_burst_seq

// ===== brs_pkg.sv
// Constants and types shared by the burst-read stall sequencer
package brs_pkg;
  localparam int         BRS_ADDR_W     = 16;
  localparam logic [1:0] BRS_REG_CONFIG = 2'h0;
  localparam logic [1:0] BRS_REG_STATUS = 2'h1;
  localparam logic [2:0] BRS_BL_4       = 3'h1;
  localparam logic [2:0] BRS_BL_8       = 3'h2;
  localparam logic [2:0] BRS_BL_CONT    = 3'h7;
  localparam logic [2:0] BRS_MASK_4     = 3'h3;
  localparam logic [2:0] BRS_MASK_8     = 3'h7;
  localparam logic [3:0] BRS_ROW_LAST   = 4'hF;
  localparam logic [2:0] BRS_SUB_01     = 3'h3;
  localparam logic [2:0] BRS_SUB_10     = 3'h2;
  localparam logic [2:0] BRS_SUB_11     = 3'h1;
  localparam logic [15:0] BRS_CFG_RESET = 16'h1C8F;

  typedef enum logic [1:0] {
    BRS_IDLE  = 2'h0,
    BRS_LAT   = 2'h1,
    BRS_DATA  = 2'h3,
    BRS_STALL = 2'h2
  } brs_st_e;

  // Configuration word layout
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic [2:0] first_access_latency;
    logic       stall_polarity;
    logic       rsvd_9;
    logic       stall_timing_select;
    logic       burst_order_select;
    logic [2:0] rsvd_mid;
    logic       wrap_select;
    logic [2:0] burst_length_field;
  } brs_cfg_s;

  // Host bus pins
  typedef struct packed {
    logic                  chip_sel_n;
    logic                  adv_n;
    logic                  reg_info;
    logic [BRS_ADDR_W-1:0] addr;
  } brs_pins_s;

  localparam brs_pins_s BRS_PINS_IDLE = '{chip_sel_n: 1'b1, adv_n: 1'b1, reg_info: 1'b0, addr: '0};

  // Register port request
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } brs_reg_req_s;

  // Status word layout
  typedef struct packed {
    logic [10:0] rsvd;
    logic        wait_act;
    logic        stall_done;
    logic        word_vld;
    brs_st_e     st;
  } brs_status_s;

  // Whole state of the sequencer
  typedef struct packed {
    brs_pins_s             pin_s1;
    brs_pins_s             pin_s2;
    brs_cfg_s              cfg;
    brs_st_e               st;
    logic [BRS_ADDR_W-1:0] start;
    logic [BRS_ADDR_W-1:0] word_addr;
    logic [3:0]            seq;
    logic [2:0]            lat_cnt;
    logic [2:0]            stall_cnt;
    logic                  stall_done;
    logic                  word_vld;
    logic                  wait_act;
    logic                  wait_pin;
    logic                  wait_oe;
    logic [15:0]           rdata;
  } brs_state_s;
endpackage : brs_pkg

// ===== brs_host_model.sv
// Host model: drives burst pins, captures words and stall behaviour
`timescale 1ns/100ps
module brs_host_model (
  // Clock
  input  wire logic                          core_clk,
  // Pins toward the sequencer
  output brs_pkg::brs_pins_s                 pins,
  // Sequencer outputs seen by the host
  input  wire logic                          wait_out,
  input  wire logic                          wait_oe,
  input  wire logic [brs_pkg::BRS_ADDR_W-1:0] word_addr,
  input  wire logic                          word_valid
);
  import brs_pkg::*;
  logic [BRS_ADDR_W-1:0] words[$];
  int                    gap_sum, gap_cnt, wait_on_word, oe_word, oe_cnt;
  initial pins = BRS_PINS_IDLE;
  // One burst; clock and chip select kept up until the host is done
  task automatic run(input logic [15:0] start, input int n, input int lim, input logic reg_rd, input logic pol);
    int gap;
    int tmo;
    words.delete();
    {gap_sum, gap_cnt, wait_on_word, oe_word, oe_cnt} = '0;
    gap = -1;
    tmo = 0;
    pins <= '{chip_sel_n: 1'b0, adv_n: 1'b0, reg_info: reg_rd, addr: start};
    @(posedge core_clk);
    pins.adv_n <= 1'b1;
    pins.addr  <= ~start; // Address no longer valid after the strobe
    while (words.size() < n && tmo < lim) begin
      @(posedge core_clk);
      tmo++;
      if (wait_oe === 1'b1) oe_cnt++;
      // Words taken only when presented, never during a stall
      if (word_valid === 1'b1) begin
        words.push_back(word_addr);
        if (wait_out === pol) wait_on_word++;
        if (wait_oe === 1'b1) oe_word++;
        if (gap > 0) begin
          gap_sum += gap;
          gap_cnt++;
        end
        gap = 0;
      end else if (gap >= 0) gap++;
    end
    pins <= BRS_PINS_IDLE;
    repeat (6) @(posedge core_clk);
  endtask : run
endmodule : brs_host_model

// ===== brs_burst_seq_tb_top.sv
// Testbench for the burst-read stall sequencer
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module brs_burst_seq_tb_top;
  import brs_pkg::*;
  typedef struct packed {
    logic [2:0] bl; logic wrap_off; logic il; logic early; logic pol;
    logic [2:0] lat; logic [15:0] start; logic [7:0] n;
  } brs_case_s;
  logic                  core_clk, reset_n, wait_out, wait_oe, word_valid;
  brs_pins_s             pins;
  brs_reg_req_s          req;
  logic [BRS_ADDR_W-1:0] word_addr;
  logic [15:0]           reg_rdata, rd;
  int                    miscompares, checks, cyc;
  brs_case_s             cases[10];

  brs_burst_seq brs_burst_seq_inst (.core_clk(core_clk), .reset_n(reset_n), .pins_in(pins),
    .wait_out(wait_out), .wait_oe(wait_oe), .word_addr(word_addr), .word_valid(word_valid),
    .reg_req(req), .reg_rdata(reg_rdata));
  brs_host_model brs_host_model_inst (.core_clk(core_clk), .pins(pins), .wait_out(wait_out),
    .wait_oe(wait_oe), .word_addr(word_addr), .word_valid(word_valid));

  // One idle cycle after each strobe keeps each request a single assignment per step
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
    @(posedge core_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : reg_rd

  function automatic logic [15:0] exp_addr(input brs_case_s k, input int i);
    logic [15:0] m;
    m = (k.bl == BRS_BL_4) ? 16'h0003 : 16'h0007;
    if (k.bl == BRS_BL_CONT || k.wrap_off) return k.start + 16'(i);
    if (k.il) return (k.start & ~m) | ((k.start ^ 16'(i)) & m);
    return (k.start & ~m) | ((k.start + 16'(i)) & m);
  endfunction : exp_addr
  // Gap only when unwrapped, misaligned, row end not the last word
  function automatic int exp_stall(input brs_case_s k);
    int d;
    d = int'(k.lat) - (4 - int'(k.start[1:0]));
    if ((k.wrap_off || k.bl == BRS_BL_CONT) && k.start[1:0] != 2'h0
        && int'(k.start[3:0]) + int'(k.n) > 16 && d > 0) return d;
    return 0;
  endfunction : exp_stall

  task automatic run_case(input brs_case_s k);
    logic [15:0] cw;
    int          s;
    cw = {2'h0, k.lat, k.pol, 1'b0, k.early, k.il, 3'h0, k.wrap_off, k.bl};
    s  = exp_stall(k);
    reg_wr(BRS_REG_CONFIG, cw);
    reg_rd(BRS_REG_CONFIG, rd);
    `CHK("config", cw, rd)
    brs_host_model_inst.run(k.start, (k.bl == BRS_BL_CONT) ? int'(k.n) : 99,
                            (k.bl == BRS_BL_CONT) ? 200 : 40, 1'b0, k.pol);
    `CHK("word_count", int'(k.n), brs_host_model_inst.words.size())
    foreach (brs_host_model_inst.words[i]) `CHK("word_addr", exp_addr(k, i), brs_host_model_inst.words[i])
    `CHK("stall_cycles", s, brs_host_model_inst.gap_sum)
    `CHK("stall_count", int'(s > 0), brs_host_model_inst.gap_cnt)
    `CHK("wait_on_word", int'(k.early && s > 0), brs_host_model_inst.wait_on_word)
    `CHK("oe_on_word", int'(k.n), brs_host_model_inst.oe_word)
  endtask : run_case

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard, far above the roughly 540 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    reset_n = 1'b0;
    req = '0;
    {miscompares, checks, cyc} = '0;
    // Fields: length, wrap off, interleave, early, polarity, latency, start, words
    cases = '{'{BRS_BL_4, 1'b0, 1'b0, 1'b0, 1'b1, 3'h3, 16'h0001, 8'h04},
              '{BRS_BL_4, 1'b0, 1'b1, 1'b0, 1'b0, 3'h3, 16'h0001, 8'h04},
              '{BRS_BL_8, 1'b0, 1'b1, 1'b0, 1'b1, 3'h4, 16'h0005, 8'h08},
              '{BRS_BL_8, 1'b0, 1'b0, 1'b0, 1'b1, 3'h7, 16'h001E, 8'h08},
              '{BRS_BL_4, 1'b1, 1'b1, 1'b0, 1'b0, 3'h4, 16'h000E, 8'h04},
              '{BRS_BL_4, 1'b1, 1'b0, 1'b1, 1'b1, 3'h5, 16'h002D, 8'h04},
              '{BRS_BL_8, 1'b1, 1'b0, 1'b0, 1'b0, 3'h4, 16'h003F, 8'h08},
              '{BRS_BL_8, 1'b1, 1'b0, 1'b0, 1'b1, 3'h6, 16'h004C, 8'h08},
              '{BRS_BL_8, 1'b1, 1'b0, 1'b0, 1'b1, 3'h3, 16'h0001, 8'h08},
              '{BRS_BL_CONT, 1'b0, 1'b1, 1'b0, 1'b1, 3'h4, 16'h001B, 8'h18}};
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    reg_rd(BRS_REG_CONFIG, rd);
    `CHK("config_reset", BRS_CFG_RESET, rd)
    reg_wr(2'h2, 16'h0000);
    reg_rd(BRS_REG_CONFIG, rd);
    `CHK("config_kept", BRS_CFG_RESET, rd)
    reg_rd(2'h3, rd);
    `CHK("unmapped", 16'h0000, rd)
    reg_rd(BRS_REG_STATUS, rd);
    `CHK("status_idle", 13'h0000, {rd[15:5], rd[1:0]})
    foreach (cases[c]) run_case(cases[c]);
    // Register information read keeps the stall pin released
    brs_host_model_inst.run(16'h000E, 4, 40, 1'b1, 1'b1);
    `CHK("oe_reg_info", 0, brs_host_model_inst.oe_cnt)
    print_verdict();
  end
endmodule : brs_burst_seq_tb_top
